// *** verilog/nvmac_top.sv ***
// nonvolatile byte access controller: registers, unlock, byte array
// assumes an avalon-mm master on clock_i; reset requests from pin and watchdog
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "nvmac_regs.svh"

// ------------------------------
// Summary of operation
// ------------------------------
// Summary of operation
// [RULE_01] pin or watchdog reset during a running write sets the error flag
// [RULE_02] error flagging leaves flash select and row erase untouched
// [RULE_03] flash erase or write needs the same unlock as byte writes
// [RULE_04] 256 byte array, 8-bit address, one 8-bit data register
// [RULE_05] a byte write erases then programs, timed by on-chip timer
// [RULE_06] unlock port stores nothing, reads zero, feeds the unlock
// [RULE_07] read and launch bits are set-only; hardware clears them
// [RULE_08] writes need write enable at one; cleared at power-up
// [RULE_09] reset that cuts a write zeroes data and address registers
// [RULE_10] write completion sets done flag; only software clears it
// [RULE_11] control bit 7 routes to flash when one, byte array when zero
// [RULE_12] control bit 6 routes to configuration space when one
// [RULE_13] row erase bit makes launch erase the pointed row, then clears
// [RULE_14] launch starts a timed cycle and reads one until it ends
// [RULE_15] read takes one cycle; read bit not settable with flash select
// [RULE_16] read byte sits in the data register on the next cycle
// [RULE_17] data register holds last read until read or firmware write
// [RULE_18] firmware loads address, clears selects, then triggers read
// [RULE_19] launch needs 55h then aah to unlock port right before it
// [RULE_20] enable must already be one; both set together starts nothing
// [RULE_21] control, address and data ignore writes while a write runs
// [RULE_22] hardware never clears write enable, only firmware or power-up
// [RULE_23] any other access returns the unlock tracker to idle
module nvmac_top
   import nvmac_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES = `NVMAC_WRITE_CYCLES,
   parameter int unsigned DEPTH = 256
) (
   input wire logic clock_i, // core clock, 250 MHz
   input wire logic nrst_i, // power-on reset, active low
   input wire logic ext_reset_i, // external reset pin request
   input wire logic wdt_reset_i, // watchdog time-out request
   input wire logic [13:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [3:0] avs_byteenable, // byte lanes
   output logic [31:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall, low when answered
   output logic busy_o, // self-timed cycle running
   output logic row_erase_o, // flash row erase running
   output logic flash_write_o, // flash row write running
   output logic [21:0] table_pointer_o // flash row pointer
);

   // ------------------------------
   // pin and watchdog request synchronisers
   // ------------------------------
   logic [1:0] ext_sync_r, wdt_sync_r;

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_sync_r <= 2'h0;
         wdt_sync_r <= 2'h0;
      end else begin
         ext_sync_r <= {ext_sync_r[0], ext_reset_i};
         wdt_sync_r <= {wdt_sync_r[0], wdt_reset_i};
      end
   end

   logic warm_rst;
   assign warm_rst = ext_sync_r[1] | wdt_sync_r[1];

   // ------------------------------
   // state
   // ------------------------------
   logic [7:0] mem [DEPTH];
   nvmac_ctl_t ctl_r, ctl_nxt;
   nvmac_unlock_t ul_r, ul_nxt;
   nvmac_op_t op_r, op_nxt;
   logic [7:0] addr_r, addr_nxt;
   logic [7:0] data_r, data_nxt;
   logic [5:0] tp_u_r, tp_u_nxt;
   logic [7:0] tp_h_r, tp_h_nxt;
   logic [7:0] tp_l_r, tp_l_nxt;
   logic [7:0] latch_r, latch_nxt;
   logic [7:0] gic_r, gic_nxt;
   logic [4:0] prio_r, prio_nxt;
   logic [4:0] flags_r, flags_nxt;
   logic [4:0] en_r, en_nxt;
   logic ack_r, ack_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic busy_r, busy_nxt;
   logic erase_r, erase_nxt;
   logic fwrite_r, fwrite_nxt;
   logic mem_we;
   logic start, abort, done;

   // ------------------------------
   // bus decode
   // ------------------------------
   function automatic logic [7:0] ctl_byte(input nvmac_ctl_t c);
      ctl_byte = {c.flash_space_select, c.config_space_select, 1'b0,
                  c.row_erase, c.write_error_flag, c.write_enable_bit,
                  c.launch, c.read_trigger};
   endfunction

   logic commit, wr_ok;
   logic [7:0] wb;
   logic [11:0] idx;
   assign commit = (avs_read | avs_write) & ack_r;
   assign wr_ok = commit & avs_write & avs_byteenable[0];
   assign wb = avs_writedata[7:0];
   // misaligned addresses land on an unmapped index
   assign idx = (avs_address[1:0] == 2'h0) ? avs_address[13:2] : 12'h000;

   logic [7:0] rbyte;
   always_comb begin
      case (idx)
         `NVMAC_OFS_PTR_U: rbyte = {2'h0, tp_u_r};
         `NVMAC_OFS_PTR_H: rbyte = tp_h_r;
         `NVMAC_OFS_PTR_L: rbyte = tp_l_r;
         `NVMAC_OFS_LATCH: rbyte = latch_r;
         `NVMAC_OFS_GIC: rbyte = gic_r;
         `NVMAC_OFS_BYTE_ADDR: rbyte = addr_r;
         `NVMAC_OFS_BYTE_DATA: rbyte = data_r;
         `NVMAC_OFS_CTL: rbyte = ctl_byte(ctl_r);
         `NVMAC_OFS_PRIO2: rbyte = {3'h0, prio_r};
         `NVMAC_OFS_FLAGS2: rbyte = {3'h0, flags_r};
         `NVMAC_OFS_EN2: rbyte = {3'h0, en_r};
         // unlock port falls through and reads zero [RULE_06]
         default: rbyte = 8'h00;
      endcase
   end

   // ------------------------------
   // next state
   // ------------------------------
   always_comb begin
      logic ctl_wr, ul_wr, launch_req;
      ctl_wr = 1'b0;
      ul_wr = 1'b0;
      launch_req = 1'b0;
      ctl_nxt = ctl_r;
      ul_nxt = ul_r;
      op_nxt = op_r;
      addr_nxt = addr_r;
      data_nxt = data_r;
      tp_u_nxt = tp_u_r;
      tp_h_nxt = tp_h_r;
      tp_l_nxt = tp_l_r;
      latch_nxt = latch_r;
      gic_nxt = gic_r;
      prio_nxt = prio_r;
      flags_nxt = flags_r;
      en_nxt = en_r;
      busy_nxt = busy_r;
      erase_nxt = 1'b0;
      fwrite_nxt = 1'b0;
      mem_we = 1'b0;
      start = 1'b0;
      abort = 1'b0;
      ack_nxt = 1'b0;
      rdata_nxt = rdata_r;

      // one wait cycle, then answer
      if ((avs_read | avs_write) & ~ack_r) begin
         ack_nxt = 1'b1;
         rdata_nxt = {24'h0, rbyte};
      end

      // read completes one cycle after the trigger [RULE_15] [RULE_16]
      if (ctl_r.read_trigger) begin
         ctl_nxt.read_trigger = 1'b0;
         if (!ctl_r.config_space_select) begin // [RULE_12]
            data_nxt = mem[addr_r];
         end
      end

      if (wr_ok) begin
         case (idx)
            `NVMAC_OFS_UNLOCK: ul_wr = 1'b1;
            `NVMAC_OFS_CTL: ctl_wr = 1'b1;
            `NVMAC_OFS_PTR_U: tp_u_nxt = wb[5:0];
            `NVMAC_OFS_PTR_H: tp_h_nxt = wb;
            `NVMAC_OFS_PTR_L: tp_l_nxt = wb;
            `NVMAC_OFS_LATCH: latch_nxt = wb;
            `NVMAC_OFS_GIC: gic_nxt = wb;
            `NVMAC_OFS_PRIO2: prio_nxt = wb[4:0];
            `NVMAC_OFS_FLAGS2: flags_nxt = wb[4:0];
            `NVMAC_OFS_EN2: en_nxt = wb[4:0];
            `NVMAC_OFS_BYTE_ADDR: begin
               if (!busy_r) addr_nxt = wb; // [RULE_04] [RULE_21]
            end
            `NVMAC_OFS_BYTE_DATA: begin
               if (!busy_r) data_nxt = wb; // [RULE_17] [RULE_21]
            end
            default: ;
         endcase
      end

      // control register writes
      if (ctl_wr && !busy_r) begin // [RULE_21]
         ctl_nxt.flash_space_select = wb[`NVMAC_CTL_FLASH];
         ctl_nxt.config_space_select = wb[`NVMAC_CTL_CFG];
         ctl_nxt.row_erase = wb[`NVMAC_CTL_FREE];
         ctl_nxt.write_error_flag = wb[`NVMAC_CTL_ERR];
         ctl_nxt.write_enable_bit = wb[`NVMAC_CTL_WEN]; // [RULE_22]
         // set-only, blocked while flash is selected [RULE_07] [RULE_15]
         if (wb[`NVMAC_CTL_RD] && !wb[`NVMAC_CTL_FLASH]) begin
            ctl_nxt.read_trigger = 1'b1;
         end
         // launch only right after the keys, enable already one
         launch_req = wb[`NVMAC_CTL_WR] && (ul_r == NVMAC_UL_ARMED)
                      && ctl_r.write_enable_bit; // [RULE_19] [RULE_20]
      end

      // unlock tracker [RULE_03] [RULE_19] [RULE_23]
      if (commit) begin
         ul_nxt = NVMAC_UL_IDLE;
         if (ul_wr && !busy_r) begin
            if (wb == `NVMAC_KEY_FIRST) begin
               ul_nxt = NVMAC_UL_FIRST;
            end else if (wb == `NVMAC_KEY_SECOND &&
                         ul_r == NVMAC_UL_FIRST) begin
               ul_nxt = NVMAC_UL_ARMED;
            end
         end
      end

      // launch a self-timed cycle [RULE_08] [RULE_14]
      if (launch_req) begin
         ctl_nxt.launch = 1'b1;
         busy_nxt = 1'b1;
         start = 1'b1;
         if (!wb[`NVMAC_CTL_FLASH]) begin
            op_nxt = NVMAC_OP_BYTE_WRITE; // [RULE_05] [RULE_11]
         end else if (wb[`NVMAC_CTL_FREE]) begin
            op_nxt = NVMAC_OP_ROW_ERASE; // [RULE_13]
         end else begin
            op_nxt = NVMAC_OP_FLASH_WRITE;
         end
      end

      if (busy_r) begin
         erase_nxt = (op_r == NVMAC_OP_ROW_ERASE);
         fwrite_nxt = (op_r == NVMAC_OP_FLASH_WRITE);
      end

      // completion of the timed cycle
      if (done && busy_r) begin
         busy_nxt = 1'b0;
         erase_nxt = 1'b0;
         fwrite_nxt = 1'b0;
         ctl_nxt.launch = 1'b0; // [RULE_07] [RULE_14]
         flags_nxt[`NVMAC_FLAGS2_DONE] = 1'b1; // [RULE_10]
         if (op_r == NVMAC_OP_ROW_ERASE) begin
            ctl_nxt.row_erase = 1'b0; // [RULE_13]
         end
         if (op_r == NVMAC_OP_BYTE_WRITE &&
             !ctl_r.config_space_select) begin
            mem_we = 1'b1; // [RULE_05]
         end
      end

      // warm reset from pin or watchdog
      if (warm_rst) begin
         abort = 1'b1;
         busy_nxt = 1'b0;
         erase_nxt = 1'b0;
         fwrite_nxt = 1'b0;
         mem_we = 1'b0;
         ul_nxt = NVMAC_UL_IDLE;
         ctl_nxt.launch = 1'b0;
         ctl_nxt.read_trigger = 1'b0;
         addr_nxt = `NVMAC_RST_BYTE; // [RULE_09]
         data_nxt = `NVMAC_RST_BYTE; // [RULE_09]
         if (busy_r) begin
            ctl_nxt.write_error_flag = 1'b1; // [RULE_01]
            ctl_nxt.row_erase = ctl_r.row_erase; // [RULE_02]
            ctl_nxt.flash_space_select = ctl_r.flash_space_select;
         end else if (!ctl_r.write_error_flag) begin
            // a flagged cut keeps its trace while the pin is held [RULE_02]
            ctl_nxt.row_erase = 1'b0;
         end
      end
   end

   // ------------------------------
   // registers
   // ------------------------------
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctl_r <= '0; // [RULE_08]
         ul_r <= NVMAC_UL_IDLE;
         op_r <= NVMAC_OP_BYTE_WRITE;
         addr_r <= `NVMAC_RST_BYTE;
         data_r <= `NVMAC_RST_BYTE;
         tp_u_r <= 6'h00;
         tp_h_r <= 8'h00;
         tp_l_r <= 8'h00;
         latch_r <= 8'h00;
         gic_r <= 8'h00;
         prio_r <= `NVMAC_RST_PRIO2;
         flags_r <= `NVMAC_RST_FLAGS2;
         en_r <= `NVMAC_RST_EN2;
         ack_r <= 1'b0;
         rdata_r <= 32'h0;
         busy_r <= 1'b0;
         erase_r <= 1'b0;
         fwrite_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         ul_r <= ul_nxt;
         op_r <= op_nxt;
         addr_r <= addr_nxt;
         data_r <= data_nxt;
         tp_u_r <= tp_u_nxt;
         tp_h_r <= tp_h_nxt;
         tp_l_r <= tp_l_nxt;
         latch_r <= latch_nxt;
         gic_r <= gic_nxt;
         prio_r <= prio_nxt;
         flags_r <= flags_nxt;
         en_r <= en_nxt;
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
         busy_r <= busy_nxt;
         erase_r <= erase_nxt;
         fwrite_r <= fwrite_nxt;
      end
   end

   // byte array, erase-before-write folded into one update [RULE_05]
   always_ff @(posedge clock_i) begin
      if (mem_we) begin
         mem[addr_r] <= data_r;
      end
   end

   // ------------------------------
   // write timer
   // ------------------------------
   nvmac_timer #(
      .CYCLES(WRITE_CYCLES)
   ) u_timer (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .start_i(start),
      .abort_i(abort),
      .done_o(done)
   );

   // ------------------------------
   // outputs
   // ------------------------------
   assign avs_readdata = rdata_r;
   assign avs_waitrequest = ~ack_r;
   assign busy_o = busy_r;
   assign row_erase_o = erase_r;
   assign flash_write_o = fwrite_r;
   assign table_pointer_o = {tp_u_r, tp_h_r, tp_l_r};

endmodule

// *** verilog/nvmac_regs.svh ***
// register offsets, field positions, reset values and timing counts
// assumes a 250 MHz clock and word-indexed register offsets
`ifndef NVMAC_REGS_SVH
`define NVMAC_REGS_SVH

// register indices (byte address is four times the index)
`define NVMAC_OFS_PTR_U 12'hff8
`define NVMAC_OFS_PTR_H 12'hff7
`define NVMAC_OFS_PTR_L 12'hff6
`define NVMAC_OFS_LATCH 12'hff5
`define NVMAC_OFS_GIC 12'hff2
`define NVMAC_OFS_BYTE_ADDR 12'hfa9
`define NVMAC_OFS_BYTE_DATA 12'hfa8
`define NVMAC_OFS_UNLOCK 12'hfa7
`define NVMAC_OFS_CTL 12'hfa6
`define NVMAC_OFS_PRIO2 12'hfa2
`define NVMAC_OFS_FLAGS2 12'hfa1
`define NVMAC_OFS_EN2 12'hfa0

// control register fields
`define NVMAC_CTL_FLASH 7
`define NVMAC_CTL_CFG 6
`define NVMAC_CTL_FREE 4
`define NVMAC_CTL_ERR 3
`define NVMAC_CTL_WEN 2
`define NVMAC_CTL_WR 1
`define NVMAC_CTL_RD 0

// flag register field
`define NVMAC_FLAGS2_DONE 4

// reset values
`define NVMAC_RST_PRIO2 5'h1f
`define NVMAC_RST_FLAGS2 5'h00
`define NVMAC_RST_EN2 5'h00
`define NVMAC_RST_BYTE 8'h00

// unlock keys
`define NVMAC_KEY_FIRST 8'h55
`define NVMAC_KEY_SECOND 8'haa

// self-timed write duration
`define NVMAC_WRITE_TIME_NS 2000000
`define NVMAC_CLK_PERIOD_NS 4
`define NVMAC_WRITE_CYCLES (`NVMAC_WRITE_TIME_NS / `NVMAC_CLK_PERIOD_NS)

`endif

// *** verilog/nvmac_pkg.sv ***
// types shared by the nonvolatile access controller
// assumes the constants of nvmac_regs.svh
package nvmac_pkg;

   // control register image, bit 5 unimplemented
   typedef struct packed {
      logic flash_space_select;
      logic config_space_select;
      logic row_erase;
      logic write_error_flag;
      logic write_enable_bit;
      logic launch;
      logic read_trigger;
   } nvmac_ctl_t;

   typedef enum logic [1:0] {
      NVMAC_UL_IDLE,
      NVMAC_UL_FIRST,
      NVMAC_UL_ARMED
   } nvmac_unlock_t;

   typedef enum logic [1:0] {
      NVMAC_OP_BYTE_WRITE,
      NVMAC_OP_ROW_ERASE,
      NVMAC_OP_FLASH_WRITE
   } nvmac_op_t;

endpackage

// *** verilog/nvmac_timer.sv ***
// self-timed write interval counter
// assumes start is a same-clock single-cycle pulse; abort is a same-clock level held while a warm reset lasts
`timescale 1ns/1ns
module nvmac_timer #(
   parameter int unsigned CYCLES = 500000
) (
   input wire logic clock_i, // core clock
   input wire logic nrst_i, // power-on reset, active low
   input wire logic start_i, // begin an interval
   input wire logic abort_i, // cancel the interval
   output logic done_o // one-cycle pulse at the end
);
   localparam int W = $clog2(CYCLES + 1);

   logic [W-1:0] cnt_r, cnt_nxt;
   logic done_r, done_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      done_nxt = 1'b0;
      if (abort_i) begin
         cnt_nxt = '0;
      end else if (start_i) begin
         cnt_nxt = W'(CYCLES);
      end else if (cnt_r != '0) begin
         cnt_nxt = cnt_r - W'(1);
         done_nxt = (cnt_r == W'(1));
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r <= '0;
         done_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         done_r <= done_nxt;
      end
   end

   assign done_o = done_r;
endmodule

// *** dv/nvmac_chk.sv ***
// concurrent checks on the ports of nvmac_top
// assumes one clock domain; bound to the design at the foot of this file
`timescale 1ns/1ns
`include "nvmac_regs.svh"
module nvmac_chk #(
   parameter int unsigned WRITE_CYCLES = 20
) (
   input wire logic clock_i, // core clock
   input wire logic nrst_i, // reset, active low
   input wire logic ext_reset_i, // pin reset request
   input wire logic wdt_reset_i, // watchdog request
   input wire logic [13:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [31:0] avs_writedata, // write data
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest, // stall
   input wire logic busy_o, // timed cycle running
   input wire logic row_erase_o, // row erase running
   input wire logic flash_write_o // flash write running
);
   localparam logic [13:0] A_CTL = {`NVMAC_OFS_CTL, 2'b00};
   localparam logic [13:0] A_KEY = {`NVMAC_OFS_UNLOCK, 2'b00};
   logic [31:0] cnt_r, cnt_nxt;
   logic abort_r, abort_nxt;
   logic [1:0] launch_r, launch_nxt;

   // ------------------------------------------------------------
   // helpers: busy length, cut writes, recent launch commits
   // ------------------------------------------------------------
   always_comb begin
      cnt_nxt = busy_o ? cnt_r + 32'd1 : 32'd0;
      abort_nxt = ext_reset_i | wdt_reset_i | (abort_r & busy_o);
      launch_nxt = {launch_r[0], avs_write & ~avs_waitrequest
         & (avs_address == A_CTL) & avs_writedata[1]};
   end
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r <= 32'd0;
         abort_r <= 1'b0;
         launch_r <= 2'b00;
      end else begin
         cnt_r <= cnt_nxt;
         abort_r <= abort_nxt;
         launch_r <= launch_nxt;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   sequence s_ans;
      !avs_waitrequest;
   endsequence
   sequence s_rd_ans(a);
      avs_read && !avs_waitrequest && avs_address == a;
   endsequence

   a_wait_single: assert property (s_ans |=> avs_waitrequest)
      else $error("wait low twice");
   a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> s_ans) else $error("no answer");
   a_key_zero: assert property (s_rd_ans(A_KEY) |-> avs_readdata == 32'h0)
      else $error("key read");
   a_read_width: assert property (avs_read ##0 s_ans |->
      avs_readdata[31:8] == 24'h0) else $error("upper bits");
   a_busy_length: assert property ($fell(busy_o) && !abort_r |->
      cnt_r == WRITE_CYCLES + 1) else $error("busy length");
   a_busy_cause: assert property ($rose(busy_o) |-> |launch_r)
      else $error("busy cause");
   a_op_busy: assert property (row_erase_o || flash_write_o |->
      busy_o && !(row_erase_o && flash_write_o))
      else $error("op outputs");
   a_launch_shown: assert property (s_rd_ans(A_CTL) ##0
      ($past(busy_o, 2) && busy_o) |-> avs_readdata[1])
      else $error("launch bit");
endmodule

bind nvmac_top nvmac_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
   .clock_i(clock_i), .nrst_i(nrst_i), .ext_reset_i(ext_reset_i),
   .wdt_reset_i(wdt_reset_i), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .busy_o(busy_o),
   .row_erase_o(row_erase_o), .flash_write_o(flash_write_o));

// *** dv/nvmac_core.sv ***
// processor core model: firmware register accesses over avalon-mm
// assumes the slave answers by dropping waitrequest for one cycle
`timescale 1ns/1ns
`include "nvmac_regs.svh"
module nvmac_core (
   input wire logic clock_i, // core clock
   input wire logic [31:0] avs_readdata, // read data
   input wire logic avs_waitrequest, // stall
   output logic [13:0] avs_address, // byte address
   output logic avs_read, // read request
   output logic avs_write, // write request
   output logic [31:0] avs_writedata, // write data
   output logic [3:0] avs_byteenable // byte lanes
);
   initial begin
      avs_address = 14'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'h0;
   end

   // ------------------------------------------------------------
   // bus cycles; released address, data and byte lanes show the inverse of the last value
   // ------------------------------------------------------------
   task automatic xfer(input logic w, input logic [11:0] ofs,
         input logic [7:0] d, output logic [7:0] q);
      avs_address <= {ofs, 2'b00};
      avs_writedata <= {24'h0, d};
      avs_byteenable <= 4'h1;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clock_i);
      while (avs_waitrequest !== 1'b0) @(posedge clock_i);
      q = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      avs_address <= ~{ofs, 2'b00};
      avs_writedata <= ~{24'h0, d};
      avs_byteenable <= 4'he;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [11:0] ofs, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b1, ofs, d, q);
   endtask
   task automatic rd(input logic [11:0] ofs, output logic [7:0] q);
      xfer(1'b0, ofs, 8'h00, q);
   endtask
   // mode carries the select and row erase bits
   task automatic launch(input logic [7:0] mode);
      wr(`NVMAC_OFS_CTL, mode | 8'h04);
      wr(`NVMAC_OFS_UNLOCK, `NVMAC_KEY_FIRST);
      wr(`NVMAC_OFS_UNLOCK, `NVMAC_KEY_SECOND);
      wr(`NVMAC_OFS_CTL, mode | 8'h06);
   endtask
   task automatic read_byte(input logic [7:0] a, output logic [7:0] q);
      wr(`NVMAC_OFS_BYTE_ADDR, a);
      wr(`NVMAC_OFS_CTL, 8'h05);
      rd(`NVMAC_OFS_BYTE_DATA, q);
   endtask
endmodule

// *** dv/nvmac_tb_top.sv ***
// self-checking bench for nvmac_top, core model as bus master
// assumes the timed cycle is shortened to 20 clock cycles
`timescale 1ns/1ns
`include "nvmac_regs.svh"
module nvmac_tb_top;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic ext_reset_i = 1'b0;
   logic wdt_reset_i = 1'b0;
   logic [13:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable;
   logic avs_read, avs_write, avs_waitrequest;
   logic busy_o, row_erase_o, flash_write_o;
   logic [21:0] table_pointer_o;
   logic [7:0] q;
   int bad_count = 0;
   int checks_done = 0;

   always #2 clock_i = ~clock_i;

   nvmac_top #(.WRITE_CYCLES(20)) i_dut (.clock_i(clock_i),
      .nrst_i(nrst_i), .ext_reset_i(ext_reset_i),
      .wdt_reset_i(wdt_reset_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .busy_o(busy_o), .row_erase_o(row_erase_o),
      .flash_write_o(flash_write_o), .table_pointer_o(table_pointer_o));
   nvmac_core i_core (.clock_i(clock_i), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable));

   // ------------------------------------------------------------
   // compare, wait and verdict helpers
   // ------------------------------------------------------------
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
         input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t: %s got %h want %h", $time, what,
            got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_byte({7'h0, got}, {7'h0, exp}, what);
   endtask
   task automatic rd_chk(input logic [11:0] ofs, input logic [7:0] exp,
         input string what, input logic [7:0] m = 8'hff);
      i_core.rd(ofs, q);
      chk_byte(q & m, exp, what);
   endtask
   task automatic wait_idle();
      for (int n = 0; n < 100 && busy_o !== 1'b0; n++) @(posedge clock_i);
      chk_bit(busy_o, 1'b0, "busy stuck");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rd_chk(`NVMAC_OFS_PRIO2, 8'h1f, "prio rst");
      rd_chk(`NVMAC_OFS_FLAGS2, 8'h00, "flags rst");
      rd_chk(`NVMAC_OFS_CTL, 8'h00, "ctl rst");
      i_core.wr(`NVMAC_OFS_UNLOCK, 8'h12);
      rd_chk(`NVMAC_OFS_UNLOCK, 8'h00, "key port");
      i_core.wr(12'h100, 8'h33);
      rd_chk(12'h100, 8'h00, "unmapped");
      i_core.wr(`NVMAC_OFS_PTR_L, 8'ha5);
      rd_chk(`NVMAC_OFS_PTR_L, 8'ha5, "ptr low");
      chk_byte(table_pointer_o[7:0], 8'ha5, "ptr out");
      $display("test reset done");
   endtask

   task automatic t_write_read();
      i_core.wr(`NVMAC_OFS_BYTE_ADDR, 8'hff);
      i_core.wr(`NVMAC_OFS_BYTE_DATA, 8'h3c);
      i_core.launch(8'h00);
      repeat (2) @(posedge clock_i);
      chk_bit(busy_o, 1'b1, "not started");
      rd_chk(`NVMAC_OFS_CTL, 8'h02, "launch bit", 8'h02);
      i_core.wr(`NVMAC_OFS_BYTE_DATA, 8'h99);
      i_core.wr(`NVMAC_OFS_CTL, 8'h00);
      wait_idle();
      rd_chk(`NVMAC_OFS_CTL, 8'h04, "ctl");
      rd_chk(`NVMAC_OFS_BYTE_DATA, 8'h3c, "data busy");
      rd_chk(`NVMAC_OFS_FLAGS2, 8'h10, "done set", 8'h10);
      rd_chk(`NVMAC_OFS_FLAGS2, 8'h10, "done kept", 8'h10);
      i_core.wr(`NVMAC_OFS_FLAGS2, 8'h00);
      rd_chk(`NVMAC_OFS_FLAGS2, 8'h00, "done clr", 8'h10);
      i_core.wr(`NVMAC_OFS_BYTE_DATA, 8'h00);
      i_core.read_byte(8'hff, q);
      chk_byte(q, 8'h3c, "byte read");
      rd_chk(`NVMAC_OFS_CTL, 8'h00, "rd bit", 8'h01);
      rd_chk(`NVMAC_OFS_BYTE_DATA, 8'h3c, "data held");
      $display("test write_read done");
   endtask

   task automatic t_unlock_faults();
      for (int k = 0; k < 4; k++) begin
         i_core.wr(`NVMAC_OFS_CTL, k[1] ? 8'h04 : 8'h00);
         i_core.wr(`NVMAC_OFS_UNLOCK, k == 3 ? 8'haa : 8'h55);
         if (k == 2) i_core.rd(`NVMAC_OFS_FLAGS2, q);
         i_core.wr(`NVMAC_OFS_UNLOCK, k == 3 ? 8'h55 : 8'haa);
         i_core.wr(`NVMAC_OFS_CTL, k == 1 ? 8'h02 : 8'h06);
         repeat (2) @(posedge clock_i);
         chk_bit(busy_o, 1'b0, "ul");
         rd_chk(`NVMAC_OFS_CTL, 8'h00, "launch", 8'h02);
      end
      $display("test unlock_faults done");
   endtask

   task automatic t_selects();
      i_core.wr(`NVMAC_OFS_BYTE_DATA, 8'h77);
      i_core.wr(`NVMAC_OFS_CTL, 8'h41);
      rd_chk(`NVMAC_OFS_BYTE_DATA, 8'h77, "cfg");
      i_core.wr(`NVMAC_OFS_CTL, 8'h81);
      rd_chk(`NVMAC_OFS_CTL, 8'h80, "rd flash");
      $display("test selects done");
   endtask

   task automatic t_flash();
      for (int op = 0; op < 2; op++) begin
         i_core.launch(op == 0 ? 8'h90 : 8'h80);
         repeat (3) @(posedge clock_i);
         chk_bit(row_erase_o, op == 0, "erase out");
         chk_bit(flash_write_o, op == 1, "write out");
         wait_idle();
         rd_chk(`NVMAC_OFS_CTL, 8'h84, "flash ctl");
      end
      $display("test flash done");
   endtask

   task automatic t_warm_reset();
      for (int src = 0; src < 2; src++) begin
         i_core.wr(`NVMAC_OFS_BYTE_ADDR, 8'h10);
         i_core.wr(`NVMAC_OFS_BYTE_DATA, 8'h5a);
         i_core.launch(src == 0 ? 8'h90 : 8'h00);
         repeat (3) @(posedge clock_i);
         if (src == 0) ext_reset_i <= 1'b1;
         else wdt_reset_i <= 1'b1;
         repeat (4) @(posedge clock_i);
         ext_reset_i <= 1'b0;
         wdt_reset_i <= 1'b0;
         repeat (4) @(posedge clock_i);
         chk_bit(busy_o, 1'b0, "not cut");
         i_core.rd(`NVMAC_OFS_CTL, q);
         chk_byte(q, src ? 8'h0c : 8'h9c, "cut");
         rd_chk(`NVMAC_OFS_BYTE_ADDR, 8'h00, "addr cut");
         rd_chk(`NVMAC_OFS_BYTE_DATA, 8'h00, "data cut");
         i_core.wr(`NVMAC_OFS_CTL, 8'h00);
      end
      $display("test warm_reset done");
   endtask

   initial begin
      repeat (5) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      t_write_read();
      t_unlock_faults();
      t_selects();
      t_flash();
      t_warm_reset();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clock_i);
      bad_count++;
      print_verdict();
   end
endmodule
